// file: hdl/radio_frame_timing.sv
// base station frame timing: cell skew, dedicated offset, timing deviation
`timescale 1ns/1ns
`default_nettype none
module radio_frame_timing (
  input wire logic i_clk, // system clock, 100 MHz
  input wire logic i_rst, // async reset, high
  input wire logic i_align_pulse, // frame alignment pin, rising edge
  input wire rfo_pkg::frame_t i_align_sfn_low, // frame number low bits
  input wire logic [rfo_pkg::CELL_W-1:0] i_cell_index, // cell in site
  input wire logic i_req_valid, // dedicated offset request strobe
  input wire rfo_pkg::offset_req_s i_req, // requested offset
  input wire logic i_burst_valid, // uplink burst detected
  input wire rfo_pkg::burst_s i_burst, // burst description
  output logic o_chip_en, // one-cycle pulse per chip
  output rfo_pkg::sfn_t o_base_frame_number, // site frame number
  output logic o_cell_frame_start, // cell frame start pulse
  output rfo_pkg::sfn_t o_cell_frame_number, // cell frame number
  output rfo_pkg::chip_t o_cell_skew, // applied skew in chips
  output logic o_dch_active, // a dedicated offset is configured
  output logic o_dch_frame_start, // dedicated frame start pulse
  output rfo_pkg::frame_t o_dch_frame_number, // dedicated frame number
  output logic o_fractional_sel, // dedicated timing is fractional
  output rfo_pkg::chip_t o_dch_chip_offset, // applied chip offset
  output rfo_pkg::frame_t o_dch_frame_offset, // applied frame offset
  output logic o_report_valid, // deviation report strobe
  output rfo_pkg::report_s o_report, // deviation report
  output logic o_ta_valid, // timing advance response strobe
  output rfo_pkg::chip_t o_ta_value // timing advance in chips
);

  // ---------------- chip rate enable ----------------
  logic [rfo_pkg::ACC_W-1:0] acc;
  logic [rfo_pkg::ACC_W:0] acc_sum;
  logic acc_wrap;
  logic [rfo_pkg::ACC_W-1:0] next_acc;

  // exact average of 3.84 MHz; chips jitter by one clock, never bunch
  assign acc_sum = {1'b0, acc} + (rfo_pkg::ACC_W+1)'(rfo_pkg::ACC_STEP);
  assign acc_wrap = acc_sum >= (rfo_pkg::ACC_W+1)'(rfo_pkg::ACC_MOD);
  assign next_acc = acc_wrap
    ? rfo_pkg::ACC_W'(acc_sum - (rfo_pkg::ACC_W+1)'(rfo_pkg::ACC_MOD))
    : rfo_pkg::ACC_W'(acc_sum);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc <= '0;
      o_chip_en <= 1'b0;
    end else begin
      acc <= next_acc;
      o_chip_en <= acc_wrap;
    end
  end

  // ---------------- alignment pin synchroniser ----------------
  logic sync_meta;
  logic sync_stable;
  logic sync_prev;
  logic align_rise;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_meta <= 1'b0;
      sync_stable <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_meta <= i_align_pulse;
      sync_stable <= sync_meta;
      sync_prev <= sync_stable;
    end
  end

  assign align_rise = sync_stable && !sync_prev;

  // ---------------- site frame counter ----------------
  rfo_pkg::chip_t base_chip;
  rfo_pkg::sfn_t base_frame;
  logic base_last_chip;

  assign base_last_chip =
    base_chip == rfo_pkg::chip_t'(rfo_pkg::CHIPS_PER_FRAME - 1);

  // an alignment edge restarts the frame, so every cell's skew counts from one site boundary
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      base_chip <= '0;
      base_frame <= '0;
    end else if (align_rise) begin
      base_chip <= '0;
      base_frame[rfo_pkg::FRAME_W-1:0] <= i_align_sfn_low;
    end else if (o_chip_en) begin
      base_chip <= base_last_chip ? '0 : base_chip + 1'b1;
      if (base_last_chip) begin
        base_frame <= base_frame + 1'b1;
      end
    end
  end

  assign o_base_frame_number = base_frame;

  // ---------------- per-cell skew ----------------
  rfo_pkg::chip_t cell_skew;
  logic skew_borrow;
  rfo_pkg::chip_t cell_chip;
  rfo_pkg::sfn_t cell_frame;

  // one burst length per cell index keeps sync bursts disjoint
  assign cell_skew = rfo_pkg::chip_t'(i_cell_index)
    * rfo_pkg::chip_t'(rfo_pkg::BURST_CHIPS);
  assign skew_borrow = base_chip < cell_skew;
  assign cell_chip = skew_borrow
    ? rfo_pkg::chip_t'(base_chip
      + rfo_pkg::chip_t'(rfo_pkg::CHIPS_PER_FRAME) - cell_skew)
    : rfo_pkg::chip_t'(base_chip - cell_skew);
  assign cell_frame = base_frame - rfo_pkg::sfn_t'(skew_borrow);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cell_frame_start <= 1'b0;
      o_cell_frame_number <= '0;
      o_cell_skew <= '0;
    end else begin
      o_cell_frame_start <= o_chip_en && cell_chip == '0;
      o_cell_frame_number <= cell_frame;
      o_cell_skew <= cell_skew;
    end
  end

  // ---------------- dedicated channel offset ----------------
  logic q_valid;
  rfo_pkg::chip_t q_chip;
  rfo_pkg::frame_t q_frame;
  logic q_fractional;

  dch_offset_quantiser quantiser (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req_valid(i_req_valid),
    .i_req(i_req),
    .o_valid(q_valid),
    .o_chip(q_chip),
    .o_frame(q_frame),
    .o_fractional(q_fractional)
  );

  logic dch_hit;
  rfo_pkg::frame_t dch_number;

  // only the rounded offset is ever held, never the raw request
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dch_active <= 1'b0;
      o_dch_chip_offset <= '0;
      o_dch_frame_offset <= '0;
      o_fractional_sel <= 1'b0;
    end else if (q_valid) begin
      o_dch_active <= 1'b1;
      o_dch_chip_offset <= q_chip;
      o_dch_frame_offset <= q_frame;
      o_fractional_sel <= q_fractional;
    end
  end

  assign dch_hit = o_dch_active && o_chip_en
    && cell_chip == o_dch_chip_offset;
  // frame counter wraps at 256, matching the offset arithmetic
  assign dch_number = cell_frame[rfo_pkg::FRAME_W-1:0]
    - o_dch_frame_offset;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dch_frame_start <= 1'b0;
      o_dch_frame_number <= '0;
    end else begin
      o_dch_frame_start <= dch_hit;
      if (dch_hit) begin
        o_dch_frame_number <= dch_number;
      end
    end
  end

  // ---------------- uplink timing deviation ----------------
  rfo_pkg::dev_t deviation;
  logic kind_with_block;
  logic kind_conditional;
  logic report_now;
  logic ta_now;
  rfo_pkg::chip_t ta_calc;

  assign deviation = rfo_pkg::dev_t'({1'b0, cell_chip})
    - rfo_pkg::dev_t'({1'b0, i_burst.expected});
  assign kind_with_block = i_burst.kind == rfo_pkg::BURST_RACH
    || i_burst.kind == rfo_pkg::BURST_SHARED;
  assign kind_conditional = i_burst.kind == rfo_pkg::BURST_DEDICATED
    || i_burst.kind == rfo_pkg::BURST_ENH_DATA
    || i_burst.kind == rfo_pkg::BURST_ENH_RACH;
  assign report_now = i_burst_valid
    && (kind_with_block
      || (kind_conditional && i_burst.report_ok));
  // plain random access relies on its guard period and never earns an advance; only enhanced random access can
  assign ta_now = i_burst_valid && i_burst.ta_request
    && i_burst.kind == rfo_pkg::BURST_ENH_RACH;
  // a late burst needs that much advance; an early one needs none
  assign ta_calc = deviation > 0
    ? rfo_pkg::chip_t'(deviation) : '0;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_report_valid <= 1'b0;
      o_report <= '0;
      o_ta_valid <= 1'b0;
      o_ta_value <= '0;
    end else begin
      o_report_valid <= report_now;
      o_ta_valid <= ta_now;
      if (report_now) begin
        o_report.kind <= i_burst.kind;
        o_report.deviation <= deviation;
        o_report.with_block <= kind_with_block;
      end
      if (ta_now) begin
        o_ta_value <= ta_calc;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_align_seen;
    align_rise ##1 1'b1;
  endsequence

  a_chip_spacing: assert property (
    o_chip_en |=> !o_chip_en ##1 !o_chip_en)
    else $error("chip enable pulses too close");

  a_frame_aligned: assert property (
    align_rise |=> base_chip == '0)
    else $error("frame boundary not restarted on alignment");

  a_sfn_low_aligned: assert property (
    s_align_seen |-> base_frame[rfo_pkg::FRAME_W-1:0]
      == $past(i_align_sfn_low))
    else $error("frame number low bits not aligned");

  a_skew_position: assert property (
    o_cell_frame_start |-> $past(base_chip) == $past(cell_skew)
      && $past(o_chip_en))
    else $error("cell frame start not at skewed position");

  a_dch_on_grid: assert property (
    o_dch_active |-> o_dch_chip_offset[rfo_pkg::GRID_SHIFT-1:0] == '0)
    else $error("dedicated offset is off the grid");

  a_dch_timing: assert property (
    o_dch_frame_start |-> $past(cell_chip) == $past(o_dch_chip_offset)
      && $past(o_dch_active))
    else $error("dedicated frame start at wrong chip");

  a_rach_forward: assert property (
    i_burst_valid && i_burst.kind == rfo_pkg::BURST_RACH
    |=> o_report_valid && o_report.with_block
      && o_report.deviation == $past(deviation))
    else $error("random access deviation not forwarded");

  a_gated_report: assert property (
    i_burst_valid && kind_conditional && !i_burst.report_ok
    |=> !o_report_valid)
    else $error("deviation reported without conditions");

  a_ta_response: assert property (
    i_burst_valid && i_burst.kind == rfo_pkg::BURST_ENH_RACH
      && i_burst.ta_request
    |=> o_ta_valid && o_ta_value == $past(ta_calc))
    else $error("timing advance request not answered");

  a_rach_no_ta: assert property (
    i_burst_valid && i_burst.kind == rfo_pkg::BURST_RACH
    |=> !o_ta_valid)
    else $error("timing advance given to random access");

endmodule // radio_frame_timing
`default_nettype wire

// file: shared/rfo_pkg.sv
// shared constants and carrier types for the radio frame offset timing block
package rfo_pkg;

  // clock and chip rate; the chip enable is a fractional divider
  localparam int CLK_HZ = 100_000_000;
  localparam int CHIP_HZ = 3_840_000;
  localparam int RATE_GCD = 10_000;
  localparam int ACC_STEP = CHIP_HZ / RATE_GCD;
  localparam int ACC_MOD = CLK_HZ / RATE_GCD;
  localparam int ACC_W = 14;

  // frame geometry
  localparam int CHIPS_PER_FRAME = 38400;
  localparam int SLOTS_PER_FRAME = 15;
  localparam int SLOT_CHIPS = CHIPS_PER_FRAME / SLOTS_PER_FRAME;
  localparam int BURST_DIV = 10;
  localparam int BURST_CHIPS = SLOT_CHIPS / BURST_DIV;

  // offset grid
  localparam int GRID_SHIFT = 8;
  localparam int GRID_CHIPS = 1 << GRID_SHIFT;
  localparam int HALF_GRID = GRID_CHIPS / 2;

  localparam int CHIP_W = 16;
  localparam int FRAME_W = 8;
  localparam int SFN_W = 12;
  localparam int CELL_W = 3;
  localparam int DEV_W = CHIP_W + 1;

  typedef logic [CHIP_W-1:0] chip_t;
  typedef logic [FRAME_W-1:0] frame_t;
  typedef logic [SFN_W-1:0] sfn_t;
  typedef logic signed [DEV_W-1:0] dev_t;

  typedef enum logic [2:0] {
    BURST_RACH,
    BURST_SHARED,
    BURST_DEDICATED,
    BURST_ENH_DATA,
    BURST_ENH_RACH
  } burst_kind_e;

  typedef struct packed {
    frame_t frame_off;
    chip_t chip_off;
    logic fractional;
  } offset_req_s;

  typedef struct packed {
    burst_kind_e kind;
    chip_t expected;
    logic ta_request;
    logic report_ok;
  } burst_s;

  typedef struct packed {
    burst_kind_e kind;
    dev_t deviation;
    logic with_block;
  } report_s;

endpackage

// file: hdl/dch_offset_quantiser.sv
// rounds a requested frame plus chip offset onto the 256-chip grid
`timescale 1ns/1ns
`default_nettype none
module dch_offset_quantiser (
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset, high
  input wire logic i_req_valid, // offset request strobe
  input wire rfo_pkg::offset_req_s i_req, // requested offset
  output logic o_valid, // quantised result strobe
  output rfo_pkg::chip_t o_chip, // quantised chip part
  output rfo_pkg::frame_t o_frame, // frame part after carry
  output logic o_fractional // request was for fractional channel
);

  logic [rfo_pkg::CHIP_W:0] half_sum;
  logic [rfo_pkg::CHIP_W:0] rounded;
  logic wrap;
  rfo_pkg::chip_t next_chip;
  rfo_pkg::frame_t next_frame;

  // adding half a grid then truncating rounds a tie upward
  assign half_sum = {1'b0, i_req.chip_off}
    + (rfo_pkg::CHIP_W+1)'(rfo_pkg::HALF_GRID);
  assign rounded = {half_sum[rfo_pkg::CHIP_W:rfo_pkg::GRID_SHIFT],
    rfo_pkg::GRID_SHIFT'(0)};
  assign wrap = rounded >= (rfo_pkg::CHIP_W+1)'(rfo_pkg::CHIPS_PER_FRAME);
  // a frame is a whole number of grid steps, so the wrap stays on grid
  assign next_chip = wrap
    ? rfo_pkg::CHIP_W'(rounded
      - (rfo_pkg::CHIP_W+1)'(rfo_pkg::CHIPS_PER_FRAME))
    : rfo_pkg::CHIP_W'(rounded);
  assign next_frame = i_req.frame_off + rfo_pkg::frame_t'(wrap);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_chip <= '0;
      o_frame <= '0;
      o_fractional <= 1'b0;
    end else begin
      o_valid <= i_req_valid;
      if (i_req_valid) begin
        o_chip <= next_chip;
        o_frame <= next_frame;
        o_fractional <= i_req.fractional;
      end
    end
  end

  a_grid_result: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_req_valid |=> o_valid && o_chip[rfo_pkg::GRID_SHIFT-1:0] == '0)
    else $error("quantised offset is off the grid");

  a_tie_rounds_up: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_req_valid && i_req.chip_off == rfo_pkg::chip_t'(rfo_pkg::HALF_GRID)
    |=> o_chip == rfo_pkg::chip_t'(rfo_pkg::GRID_CHIPS)
        && o_frame == $past(i_req.frame_off))
    else $error("half grid offset did not round up");

endmodule // dch_offset_quantiser
`default_nettype wire

// file: tb/radio_link_partner.sv
// controller and terminal stand-in that drives the block's request side
`timescale 1ns/1ns
`default_nettype none
module radio_link_partner (
  input wire logic i_clk, // system clock
  output logic o_align_pulse, // alignment pin
  output rfo_pkg::frame_t o_align_sfn_low, // frame number low bits
  output logic o_req_valid, // offset request strobe
  output rfo_pkg::offset_req_s o_req, // requested offset
  output logic o_burst_valid, // uplink burst strobe
  output rfo_pkg::burst_s o_burst // burst description
);
  initial begin
    o_align_pulse = 1'b0;
    o_align_sfn_low = '0;
    o_req_valid = 1'b0;
    o_req = '0;
    o_burst_valid = 1'b0;
    o_burst = '0;
  end

  // terminal side: whole frames wrap in 8 bits, residual passes in chips
  function automatic rfo_pkg::frame_t frame_diff(input rfo_pkg::frame_t tgt,
      input rfo_pkg::frame_t nom);
    return rfo_pkg::frame_t'(tgt - nom);
  endfunction

  // nominal timing sits a lead time before the uplink instant, so the
  // target-to-nominal difference is what goes out as the request
  task automatic send_offset(input rfo_pkg::frame_t tgt,
      input rfo_pkg::frame_t nom, input rfo_pkg::chip_t residual,
      input logic frac);
    @(posedge i_clk);
    o_req_valid <= 1'b1;
    o_req <= '{frame_off: frame_diff(tgt, nom), chip_off: residual,
        fractional: frac};
    @(posedge i_clk);
    o_req_valid <= 1'b0;
    o_req <= ~o_req; // released fields do not keep the last value
  endtask

  // random access goes out with no timing advance applied
  task automatic send_burst(input rfo_pkg::burst_kind_e k,
      input logic ta, input logic ok);
    @(posedge i_clk);
    o_burst_valid <= 1'b1;
    o_burst <= '{kind: k, expected: 16'h0100, ta_request: ta,
        report_ok: ok};
    @(posedge i_clk);
    o_burst_valid <= 1'b0;
    o_burst <= ~o_burst;
  endtask

  task automatic align(input rfo_pkg::frame_t sfn);
    @(posedge i_clk);
    o_align_pulse <= 1'b1;
    o_align_sfn_low <= sfn;
    repeat (4) @(posedge i_clk);
    o_align_pulse <= 1'b0;
  endtask
endmodule // radio_link_partner
`default_nettype wire

// file: tb/radio_frame_timing_tb_top.sv
// self-checking bench for the radio frame timing block
`timescale 1ns/1ns
`default_nettype none
module radio_frame_timing_tb_top;
  logic i_clk;
  logic i_rst;
  logic [2:0] cell_index;
  logic align_pulse;
  rfo_pkg::frame_t align_sfn;
  logic req_valid;
  rfo_pkg::offset_req_s req;
  logic burst_valid;
  rfo_pkg::burst_s burst;
  logic o_chip_en;
  rfo_pkg::sfn_t o_cell_frame_number;
  rfo_pkg::sfn_t o_base_frame_number;
  logic o_cell_frame_start;
  rfo_pkg::chip_t o_cell_skew;
  logic o_dch_active;
  logic o_dch_frame_start;
  rfo_pkg::frame_t o_dch_frame_number;
  logic o_fractional_sel;
  rfo_pkg::chip_t o_dch_chip_offset;
  rfo_pkg::frame_t o_dch_frame_offset;
  logic o_report_valid;
  rfo_pkg::report_s o_report;
  logic o_ta_valid;
  rfo_pkg::chip_t o_ta_value;
  int n_mismatch = 0;
  int compares = 0;
  int chip_model = 0;
  int chip_at_edge = 0;

  radio_link_partner PARTNER (.i_clk(i_clk), .o_align_pulse(align_pulse),
    .o_align_sfn_low(align_sfn), .o_req_valid(req_valid), .o_req(req),
    .o_burst_valid(burst_valid), .o_burst(burst));

  radio_frame_timing DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_align_pulse(align_pulse), .i_align_sfn_low(align_sfn),
    .i_cell_index(cell_index), .i_req_valid(req_valid), .i_req(req),
    .i_burst_valid(burst_valid), .i_burst(burst), .o_chip_en(o_chip_en),
    .o_base_frame_number(o_base_frame_number),
    .o_cell_frame_start(o_cell_frame_start),
    .o_cell_frame_number(o_cell_frame_number), .o_cell_skew(o_cell_skew),
    .o_dch_active(o_dch_active), .o_dch_frame_start(o_dch_frame_start),
    .o_dch_frame_number(o_dch_frame_number),
    .o_fractional_sel(o_fractional_sel),
    .o_dch_chip_offset(o_dch_chip_offset),
    .o_dch_frame_offset(o_dch_frame_offset),
    .o_report_valid(o_report_valid), .o_report(o_report),
    .o_ta_valid(o_ta_valid), .o_ta_value(o_ta_value));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // mirrors the cell chip counter once the 256-chip dedicated start passed;
  // chip_at_edge is the cell chip that the last edge measured against
  always @(posedge i_clk) begin
    chip_at_edge <= chip_model;
    if (o_dch_frame_start === 1'b1) begin
      chip_model <= 257;
    end else if (o_chip_en === 1'b1) begin
      chip_model <= chip_model + 1;
    end
  end

  task automatic final_report;
    $display("mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic t_reset;
    check(o_dch_active, 0, "dch active in reset");
    check(o_report_valid, 0, "report in reset");
    check(o_ta_valid, 0, "ta in reset");
    check(o_base_frame_number, 0, "frame number in reset");
  endtask

  // ties round up, plain cases round to nearest, chip overflow carries
  task automatic t_quant;
    logic [15:0] chips [5] = '{16'h0080, 16'h007F, 16'h95C0, 16'h3180,
        16'h95FF};
    logic [15:0] exp_c [5] = '{16'h0100, 16'h0000, 16'h0000, 16'h3200,
        16'h0000};
    logic [7:0] exp_f [5] = '{8'h05, 8'h05, 8'h06, 8'h05, 8'h06};
    for (int i = 0; i < 5; i++) begin
      PARTNER.send_offset(8'h06, 8'h01, chips[i], i[0]);
      repeat (2) @(posedge i_clk);
      #1;
      check(o_dch_chip_offset, exp_c[i], "chip offset");
      check(o_dch_frame_offset, exp_f[i], "frame offset");
      check(o_fractional_sel, i[0], "fractional");
      check(o_dch_active, 1, "dch active");
    end
  endtask

  // skew is one sync burst per cell position
  task automatic t_skew;
    for (int i = 7; i >= 1; i--) begin
      @(posedge i_clk);
      cell_index <= 3'(i);
      repeat (2) @(posedge i_clk);
      #1;
      check(o_cell_skew, i * rfo_pkg::BURST_CHIPS, "cell skew");
    end
  endtask

  task automatic t_align;
    PARTNER.align(8'hA5);
    repeat (4) @(posedge i_clk);
    #1;
    check(o_base_frame_number[7:0], 8'hA5, "aligned frame");
    check(o_cell_frame_number[7:0], 8'hA4, "cell frame");
  endtask

  task automatic t_dch;
    int cnt;
    int n;
    PARTNER.send_offset(8'h08, 8'h01, 16'h0100, 1'b0);
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_cell_frame_start !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      n_mismatch++;
      final_report();
    end
    cnt = 0;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
      if (o_chip_en === 1'b1) cnt++;
    end while (o_dch_frame_start !== 1'b1 && n < 10000);
    if (n >= 10000) begin
      n_mismatch++;
      final_report();
    end
    check(cnt, 256, "chips cell to dch start");
    // aligned frame A5 less the applied frame offset of 7
    check(o_dch_frame_number, 8'h9E, "dch frame number");
    @(posedge i_clk);
    #1;
    check(o_dch_frame_start, 0, "dch start one cycle");
  endtask

  // every burst kind, with and without reporting and advance request
  task automatic t_burst;
    logic rep;
    logic blk;
    logic ta_exp;
    int dev_exp;
    for (int k = 0; k < 5; k++) begin
      for (int c = 0; c < 4; c++) begin
        PARTNER.send_burst(rfo_pkg::burst_kind_e'(k), c[1], c[0]);
        // the strobes stand only in the cycle after the taking edge
        #1;
        blk = (k <= 1);
        rep = blk || c[0];
        ta_exp = (k == 4) && c[1];
        // the partner expects every burst at cell chip 256
        dev_exp = chip_at_edge - 256;
        check(o_report_valid, rep, "report strobe");
        if (rep) begin
          check(o_report.kind, k, "report kind");
          check(o_report.with_block, blk, "with block");
          check(o_report.deviation, dev_exp, "deviation");
        end
        check(o_ta_valid, ta_exp, "ta strobe");
        if (ta_exp) begin
          check(o_ta_value, dev_exp > 0 ? dev_exp : 0,
              "ta value");
        end
      end
    end
  endtask

  initial begin
    i_rst = 1'b1;
    cell_index = '0;
    repeat (2) @(posedge i_clk);
    #1;
    t_reset();
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_quant();
    t_skew();
    t_align();
    t_dch();
    t_burst();
    final_report();
  end
endmodule // radio_frame_timing_tb_top
`default_nettype wire
